// ### ee2w_target.sv
// two-wire serial eeprom target, write path
//
// Summary of operation
// - data changing while the clock is high marks start or stop
// - falling data with clock high is a start, seen at any time except while programming
// - rising data with clock high is a stop, closing the operation
// - standby at reset and after stop once programming is done
// - bytes are eight bits; device pulls data low on ninth clock
// - select word top four bits must equal the type code
// - next three select bits must match the strap pins
// - last select bit high means read, low means write
// - matching select is acknowledged, otherwise rest is ignored
// - write protect high blocks programming of the upper quarter
// - two address bytes then data, each acknowledged
// - self-timed cycle after stop; inputs ignored, no answer
// - page write takes up to 32 data bytes, each acknowledged
// - only low five address bits count up, wrapping in the page
// - select is acknowledged only after programming has finished
// - spikes under the noise limit are ignored in start/stop detection; bits take the raw pins
// - 256 pages of 32 bytes, thirteen-bit word address
// - bits sampled on rising clock, ack driven after falling clock
module ee2w_target import ee2w_pkg::*; #(
  parameter logic [TIMER_W-1:0] WR_CYCLES =
    TIMER_W'(SELF_TIMED_PROGRAM_CYC),
  parameter logic [3:0] DEV_TYPE = 4'h5  // arbitrary value
) (
  input wire logic clk_i,                  // core clock, 20 MHz
  input wire logic rst_n_i,                // async reset, active low
  input wire logic scl_i,                  // serial clock, link clock
  input wire logic sda_i,                  // serial data, wire level
  output logic sda_o,                      // serial data out level
  output logic sda_oe_o,                   // high pulls data line low
  input wire logic select_strap_bit2_i,    // select strap, bit 2
  input wire logic select_strap_bit1_i,    // select strap, bit 1
  input wire logic select_strap_bit0_i,    // select strap, bit 0
  input wire logic wp_i,                   // write protect pin
  output logic mem_we_o,                   // array byte write strobe
  output logic [ADDR_W-1:0] mem_addr_o,    // array byte address
  output logic [BYTE_W-1:0] mem_data_o,    // array write data
  output logic standby_o,                  // low-power standby
  output logic write_busy_o                // programming in progress
);

  // ----------------------------------------------------------------
  // state records
  // ----------------------------------------------------------------
  typedef struct packed {
    ee2w_core_st_type st;
    logic sda_prev;
    logic run;
    logic [1:0] rstcnt;
    logic has_meta;
    logic has_sync;
    logic [OFS_W-1:0] idx;
    logic tmr_start;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] data;
    logic standby;
    logic busy;
  } ee2w_core_type;

  typedef struct packed {
    ee2w_lnk_st_type st;
    logic [3:0] bitcnt;
    logic [BYTE_W-1:0] shreg;
    logic ack_req;
    logic [ADDR_W-1:0] addr;
    logic has_data;
  } ee2w_lnk_type;

  typedef struct packed {
    logic [PAGE_BYTES-1:0][BYTE_W-1:0] data;
    logic [PAGE_BYTES-1:0] valid;
    logic [PAGE_W-1:0] page;
  } ee2w_buf_type;

  ee2w_core_type c_r;
  ee2w_core_type c_nxt;
  ee2w_lnk_type l_r;
  ee2w_lnk_type l_nxt;
  ee2w_buf_type b_r;
  ee2w_buf_type b_nxt;
  logic sda_oe_r;

  logic scl_f;
  logic sda_f;
  logic wp_s;
  logic [STRAP_W-1:0] strap_raw;
  logic [STRAP_W-1:0] strap_s;
  logic tmr_busy;
  logic start_ev;
  logic stop_ev;
  logic lnk_arst_n;
  logic [BYTE_W-1:0] rx_byte;
  logic sel_match;
  logic [OFS_W-1:0] prog_ofs;
  logic prog_ok;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // spike filters on both bus lines for condition detection
  // both lines share one filter design, so their order of change is kept;
  // the price is the same few cycles of latency on both
  ee2w_pin_filter #(.RST_LEVEL(1'b1)) u_scl_filt (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(scl_i),
    .level_o(scl_f)
  );

  ee2w_pin_filter #(.RST_LEVEL(1'b1)) u_sda_filt (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(sda_i),
    .level_o(sda_f)
  );

  ee2w_pin_filter #(.RST_LEVEL(1'b0)) u_wp_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(wp_i),
    .level_o(wp_s)
  );

  // unconnected straps are pulled low outside, so they read as zero
  assign strap_raw = {select_strap_bit2_i, select_strap_bit1_i,
                      select_strap_bit0_i};

  // straps are static; the link reads the synced copy as quasi-static
  for (genvar g = 0; g < STRAP_W; g++) begin : g_strap
    ee2w_pin_filter #(.RST_LEVEL(1'b0)) u_strap_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .pin_i(strap_raw[g]),
      .level_o(strap_s[g])
    );
  end

  // ----------------------------------------------------------------
  // program cycle timer
  // ----------------------------------------------------------------
  // timer starts one cycle after the stop is seen, then runs unattended
  ee2w_wr_timer #(.CYCLES(WR_CYCLES)) u_wr_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .start_i(c_r.tmr_start),
    .busy_o(tmr_busy)
  );

  // ----------------------------------------------------------------
  // core domain: conditions, frame control, programming
  // ----------------------------------------------------------------
  // bus conditions from filtered levels
  assign start_ev = scl_f & c_r.sda_prev & ~sda_f;
  assign stop_ev = scl_f & ~c_r.sda_prev & sda_f;

  // buffer is stable here: the link is held in reset while programming
  assign prog_ofs = c_r.idx;
  assign prog_ok = b_r.valid[prog_ofs] &&
    !(wp_s && b_r.page[PAGE_W-1 -: 2] == WP_QUARTER);

  always_comb begin
    c_nxt = c_r;
    c_nxt.sda_prev = sda_f;
    c_nxt.has_meta = l_r.has_data;
    c_nxt.has_sync = c_r.has_meta;
    c_nxt.tmr_start = 1'b0;
    c_nxt.we = 1'b0;
    case (c_r.st)
      CORE_IDLE, CORE_FRAME: begin
        if (start_ev) begin
          // a start in idle or mid-frame restarts the link, repeated or not
          c_nxt.st = CORE_FRAME;
          c_nxt.run = 1'b0;
          c_nxt.rstcnt = LINK_RST_CYC;
        end else if (c_r.st == CORE_FRAME && stop_ev) begin
          c_nxt.run = 1'b0;
          if (c_r.has_sync) begin
            c_nxt.st = CORE_PROG;
            c_nxt.idx = '0;
            c_nxt.tmr_start = 1'b1;
          end else begin
            c_nxt.st = CORE_IDLE;
          end
        end else if (c_r.st == CORE_FRAME && c_r.rstcnt != 2'h0) begin
          // release before the first falling clock of the frame
          c_nxt.rstcnt = 2'(c_r.rstcnt - 1'b1);
          c_nxt.run = (c_r.rstcnt == 2'h1);
        end
      end
      CORE_PROG: begin
        // one buffered byte per cycle; skipped slots are not touched
        // a protected or unwritten slot still costs its cycle of the scan
        if (prog_ok) begin
          c_nxt.we = 1'b1;
          c_nxt.addr = {b_r.page, prog_ofs};
          c_nxt.data = b_r.data[prog_ofs];
        end
        c_nxt.idx = OFS_W'(c_r.idx + 1'b1);
        if (c_r.idx == OFS_LAST) begin
          c_nxt.st = CORE_WAIT;
        end
      end
      CORE_WAIT: begin
        // link stays in reset, so polls go unanswered until done
        if (!tmr_busy) begin
          c_nxt.st = CORE_IDLE;
        end
      end
      default: begin
        c_nxt.st = CORE_IDLE;
        c_nxt.run = 1'b0;
      end
    endcase
    c_nxt.standby = (c_nxt.st == CORE_IDLE);
    c_nxt.busy = (c_nxt.st == CORE_PROG) || (c_nxt.st == CORE_WAIT);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      c_r <= '{st: CORE_IDLE, sda_prev: 1'b1, run: 1'b0, rstcnt: 2'h0,
               has_meta: 1'b0, has_sync: 1'b0, idx: '0,
               tmr_start: 1'b0, we: 1'b0, addr: '0, data: '0,
               standby: 1'b1, busy: 1'b0};
    end else begin
      c_r <= c_nxt;
    end
  end

  // ----------------------------------------------------------------
  // link domain: byte engine on the serial clock
  // ----------------------------------------------------------------
  // limitation: the link leaves reset some seven core cycles after the
  // start is seen, so the start hold must outlast that or bit one is lost
  // frame reset comes from a core flop, so it is glitch free
  assign lnk_arst_n = rst_n_i & c_r.run;

  assign rx_byte = {l_r.shreg[BYTE_W-2:0], sda_i};
  assign sel_match =
    (rx_byte[BYTE_W-1:SEL_TYPE_LSB] == DEV_TYPE) &&
    (rx_byte[SEL_STRAP_LSB +: STRAP_W] == strap_s);

  always_comb begin
    l_nxt = l_r;
    b_nxt = b_r;
    if (l_r.bitcnt == BIT_ACK) begin
      // ninth clock: acknowledge slot ends
      l_nxt.bitcnt = 4'h0;
      l_nxt.ack_req = 1'b0;
    end else begin
      l_nxt.shreg = rx_byte;
      l_nxt.bitcnt = 4'(l_r.bitcnt + 1'b1);
      if (l_r.bitcnt == BIT_LAST) begin
        case (l_r.st)
          LNK_SEL: begin
            if (sel_match) begin
              l_nxt.ack_req = 1'b1;
              // reads are served elsewhere; this path only skips
              l_nxt.st = rx_byte[SEL_RW_BIT] ? LNK_SKIP : LNK_AHI;
            end else begin
              l_nxt.st = LNK_SKIP;
            end
          end
          LNK_AHI: begin
            // surplus high address bits are dropped here
            l_nxt.addr[ADDR_W-1:BYTE_W] = rx_byte[ADDR_HI_W-1:0];
            l_nxt.ack_req = 1'b1;
            l_nxt.st = LNK_ALO;
          end
          LNK_ALO: begin
            l_nxt.addr[BYTE_W-1:0] = rx_byte;
            l_nxt.ack_req = 1'b1;
            l_nxt.st = LNK_DATA;
            b_nxt.valid = '0;
            b_nxt.page = {l_r.addr[ADDR_W-1:BYTE_W],
                          rx_byte[BYTE_W-1:OFS_W]};
          end
          LNK_DATA: begin
            // later bytes to the same slot overwrite earlier ones
            b_nxt.data[l_r.addr[OFS_W-1:0]] = rx_byte;
            b_nxt.valid[l_r.addr[OFS_W-1:0]] = 1'b1;
            l_nxt.addr[OFS_W-1:0] =
              OFS_W'(l_r.addr[OFS_W-1:0] + 1'b1);
            l_nxt.has_data = 1'b1;
            l_nxt.ack_req = 1'b1;
          end
          LNK_SKIP: begin
            l_nxt.ack_req = 1'b0;
          end
          default: begin
            l_nxt.st = LNK_SKIP;
          end
        endcase
      end
    end
  end

  // frame state, cleared at every start and stop
  always_ff @(posedge scl_i or negedge lnk_arst_n) begin
    if (!lnk_arst_n) begin
      l_r <= '{st: LNK_SEL, bitcnt: 4'h0, shreg: '0, ack_req: 1'b0,
               addr: '0, has_data: 1'b0};
    end else begin
      l_r <= l_nxt;
    end
  end

  // page buffer outlives the frame so the core can program it
  // stale slots of an aborted frame stay behind, but the valid bits are
  // cleared at the low address byte before any reuse
  always_ff @(posedge scl_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      b_r <= '0;
    end else begin
      b_r <= b_nxt;
    end
  end

  // acknowledge changes only after the falling clock
  // shares the frame reset, so a start in mid-ack frees the wire at once
  always_ff @(negedge scl_i or negedge lnk_arst_n) begin
    if (!lnk_arst_n) begin
      sda_oe_r <= 1'b0;
    end else begin
      sda_oe_r <= l_r.ack_req;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // data value is a tie: the pin never drives high, only the enable moves
  assign sda_o = 1'b0;  // open drain: only ever pulls low
  assign sda_oe_o = sda_oe_r;
  assign mem_we_o = c_r.we;
  assign mem_addr_o = c_r.addr;
  assign mem_data_o = c_r.data;
  assign standby_o = c_r.standby;
  assign write_busy_o = c_r.busy;

endmodule // ee2w_target

// ### ee2w_pkg.sv
package ee2w_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int CLK_HZ = 20_000_000;
  // self-timed program time, longest figure of the faster grades
  localparam int SELF_TIMED_PROGRAM_TIME_MS = 10;
  // longest time rounds down to whole cycles
  localparam int SELF_TIMED_PROGRAM_CYC =
    SELF_TIMED_PROGRAM_TIME_MS * (CLK_HZ / 1000);
  localparam int TIMER_W = 19;
  // noise suppression limit of the faster grade
  localparam int NOISE_LIMIT_NS = 50;
  // least time rounds up, never below one cycle
  localparam int NOISE_CYC_RAW =
    (NOISE_LIMIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NOISE_CYC = (NOISE_CYC_RAW < 1) ? 1 : NOISE_CYC_RAW;
  localparam int FILT_CNT_W = 2;
  // cycles the link logic is held in reset after a start condition
  localparam logic [1:0] LINK_RST_CYC = 2'h2;

  // ----------------------------------------------------------------
  // array geometry and field positions
  // ----------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 13;
  localparam int PAGE_W = 8;
  localparam int OFS_W = 5;
  localparam int PAGE_BYTES = 32;
  localparam int ADDR_HI_W = ADDR_W - BYTE_W;
  localparam int SEL_TYPE_LSB = 4;
  localparam int SEL_STRAP_LSB = 1;
  localparam int SEL_RW_BIT = 0;
  localparam int STRAP_W = 3;
  // upper quarter of the array: top two page bits both set
  localparam logic [1:0] WP_QUARTER = 2'h3;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [OFS_W-1:0] OFS_LAST = 5'h1F;

  // ----------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    LNK_SEL  = 5'h01,
    LNK_AHI  = 5'h02,
    LNK_ALO  = 5'h04,
    LNK_DATA = 5'h08,
    LNK_SKIP = 5'h10
  } ee2w_lnk_st_type;

  typedef enum logic [3:0] {
    CORE_IDLE  = 4'h1,
    CORE_FRAME = 4'h2,
    CORE_PROG  = 4'h4,
    CORE_WAIT  = 4'h8
  } ee2w_core_st_type;

endpackage

// ### ee2w_pin_filter.sv
// two-flop synchroniser followed by a spike filter
module ee2w_pin_filter import ee2w_pkg::*; #(
  parameter logic RST_LEVEL = 1'b1
) (
  input wire logic clk_i,    // core clock
  input wire logic rst_n_i,  // async reset, active low
  input wire logic pin_i,    // raw pin level
  output logic level_o       // filtered level
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic level;
    logic [FILT_CNT_W-1:0] cnt;
  } ee2w_filt_type;

  ee2w_filt_type s_r;
  ee2w_filt_type s_nxt;

  // ----------------------------------------------------------------
  // filter: a change must persist past the noise limit
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.meta = pin_i;
    s_nxt.sync = s_r.meta;  // first stage read here only
    if (s_r.sync == s_r.level) begin
      s_nxt.cnt = '0;
    end else if (s_r.cnt == FILT_CNT_W'(NOISE_CYC)) begin
      s_nxt.level = s_r.sync;
      s_nxt.cnt = '0;
    end else begin
      s_nxt.cnt = FILT_CNT_W'(s_r.cnt + 1'b1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '{meta: RST_LEVEL, sync: RST_LEVEL, level: RST_LEVEL,
               cnt: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign level_o = s_r.level;

endmodule // ee2w_pin_filter

// ### ee2w_wr_timer.sv
// self-timed program cycle counter
module ee2w_wr_timer import ee2w_pkg::*; #(
  parameter logic [TIMER_W-1:0] CYCLES = TIMER_W'(SELF_TIMED_PROGRAM_CYC)
) (
  input wire logic clk_i,    // core clock
  input wire logic rst_n_i,  // async reset, active low
  input wire logic start_i,  // one-cycle start pulse
  output logic busy_o        // high while the cycle runs
);

  typedef struct packed {
    logic busy;
    logic [TIMER_W-1:0] cnt;
  } ee2w_tmr_type;

  ee2w_tmr_type t_r;
  ee2w_tmr_type t_nxt;

  // ----------------------------------------------------------------
  // down counter, restart is ignored while running
  // ----------------------------------------------------------------
  always_comb begin
    t_nxt = t_r;
    if (!t_r.busy) begin
      if (start_i) begin
        t_nxt.busy = 1'b1;
        t_nxt.cnt = TIMER_W'(CYCLES - 1'b1);
      end
    end else if (t_r.cnt == '0) begin
      t_nxt.busy = 1'b0;
    end else begin
      t_nxt.cnt = TIMER_W'(t_r.cnt - 1'b1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      t_r <= '0;
    end else begin
      t_r <= t_nxt;
    end
  end

  assign busy_o = t_r.busy;

endmodule // ee2w_wr_timer

// ### ee2w_target_assertions.sv
// ----------------------------------------------------------------
// port-level checks for the two-wire eeprom target
// ----------------------------------------------------------------
module ee2w_target_assertions import ee2w_pkg::*; #(
  parameter logic [TIMER_W-1:0] WR_CYCLES = TIMER_W'(SELF_TIMED_PROGRAM_CYC)
) (
  input wire logic clk_i,                // core clock
  input wire logic rst_n_i,              // async reset
  input wire logic scl_i,                // serial clock
  input wire logic sda_i,                // data wire level
  input wire logic sda_o,                // data out level
  input wire logic sda_oe_o,             // data pull enable
  input wire logic select_strap_bit2_i,  // strap 2
  input wire logic select_strap_bit1_i,  // strap 1
  input wire logic select_strap_bit0_i,  // strap 0
  input wire logic wp_i,                 // write protect
  input wire logic mem_we_o,             // array strobe
  input wire logic [ADDR_W-1:0] mem_addr_o, // array address
  input wire logic [BYTE_W-1:0] mem_data_o, // array data
  input wire logic standby_o,            // standby
  input wire logic write_busy_o          // programming
);
  // busy starts a few cycles after the stop, so allow slack both ways
  localparam int BUSY_MIN = int'(WR_CYCLES) - 8;
  localparam int BUSY_MAX = int'(WR_CYCLES) + 8;
  logic [TIMER_W-1:0] busy_cnt_r;
  logic [TIMER_W-1:0] busy_cnt_nxt;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // length of the current programming cycle
  always_comb busy_cnt_nxt = write_busy_o ? busy_cnt_r + 1'b1 : '0;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_cnt_r <= '0;
    end else begin
      busy_cnt_r <= busy_cnt_nxt;
    end
  end

  chk_oe_scl_low:
    assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("ack drive moved while serial clock high");
  chk_drive_low:
    assert property (sda_oe_o |-> sda_o == 1'b0)
    else $error("ack drive not low");
  chk_busy_quiet:
    assert property (write_busy_o |-> !sda_oe_o)
    else $error("answer during programming");
  chk_we_busy:
    assert property (mem_we_o |-> write_busy_o)
    else $error("array write outside programming");
  chk_wp_guard:
    assert property (mem_we_o && wp_i |->
      mem_addr_o[ADDR_W-1 -: 2] != WP_QUARTER)
    else $error("protected quarter written");
  chk_standby_idle:
    assert property (standby_o |-> !write_busy_o && !sda_oe_o)
    else $error("standby while active");
  chk_busy_rise:
    assert property ($rose(write_busy_o) |-> scl_i && !standby_o)
    else $error("programming began inside a frame");
  chk_busy_max:
    assert property (write_busy_o |-> int'(busy_cnt_r) <= BUSY_MAX)
    else $error("programming cycle too long");
  chk_busy_min:
    assert property ($fell(write_busy_o) |-> int'(busy_cnt_r) >= BUSY_MIN)
    else $error("programming cycle too short");

  cover property (mem_we_o && wp_i);
  cover property ($rose(write_busy_o));
  cover property ($rose(sda_oe_o));
endmodule // ee2w_target_assertions

bind ee2w_target ee2w_target_assertions #(.WR_CYCLES(WR_CYCLES)) u_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .select_strap_bit2_i(select_strap_bit2_i),
  .select_strap_bit1_i(select_strap_bit1_i),
  .select_strap_bit0_i(select_strap_bit0_i), .wp_i(wp_i),
  .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o),
  .standby_o(standby_o), .write_busy_o(write_busy_o));

// ### ee2w_ctrl_model.sv
// ----------------------------------------------------------------
// bus controller model; clock stands high between frames
// ----------------------------------------------------------------
module ee2w_ctrl_model (
  input wire logic sda_i,  // resolved data wire
  output logic scl_o,      // serial clock
  output logic sda_o       // 0 pulls data low, 1 releases
);
  timeunit 1ns;
  timeprecision 1ps;
  // quarter period off the core grid; each clock phase spans over two and a half core cycles
  localparam real Q = 65.3;

  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // also serves as repeated start from clock low
  task automatic frame_start();
    #(Q) sda_o = 1'b1;
    #(Q) scl_o = 1'b1;
    #(3*Q) sda_o = 1'b0;
    // long hold: the target frees its link some seven core cycles later
    #(6*Q) scl_o = 1'b0;
  endtask

  // bus recovery: clock with data released, watching for a free line
  task automatic recover(output logic free);
    free = 1'b1;
    sda_o = 1'b1;
    for (int i = 0; i < 9; i++) begin
      #(Q) scl_o = 1'b0;
      #(2*Q) scl_o = 1'b1;
      #(Q) free = free & sda_i;
    end
    #(4*Q);
  endtask

  // msb first, data moves only while clock is low
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #(Q) sda_o = b[i];
      #(Q) scl_o = 1'b1;
      #(2*Q) scl_o = 1'b0;
    end
    #(Q) sda_o = 1'b1;
    #(Q) scl_o = 1'b1;
    #(Q) ack = ~sda_i;
    #(Q) scl_o = 1'b0;
  endtask

  // long idle tail leaves the bus free before any next start
  task automatic frame_stop();
    #(Q) sda_o = 1'b0;
    #(Q) scl_o = 1'b1;
    #(3*Q) sda_o = 1'b1;
    #(12*Q);
  endtask
endmodule // ee2w_ctrl_model

// ### tb_serial_eeprom_two_wire_target.sv
module tb_serial_eeprom_two_wire_target import ee2w_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // setup
  // ----------------------------------------------------------------
  localparam logic [TIMER_W-1:0] WR_CYC = 19'h0_00C8;
  localparam logic [3:0] DEV_CODE = 4'h5; // arbitrary type code
  localparam logic [2:0] STRAP = 3'h5;
  localparam logic [7:0] SEL_W = {DEV_CODE, STRAP, 1'b0};
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wp_i = 1'b0;
  logic [2:0] strap = 3'h0;
  wire logic scl, ctl_sda, sda_w, sda_o, sda_oe_o;
  wire logic mem_we_o, standby_o, write_busy_o;
  logic [ADDR_W-1:0] mem_addr_o;
  logic [BYTE_W-1:0] mem_data_o;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  logic bus_free;
  logic [ADDR_W-1:0] wa[$];
  logic [BYTE_W-1:0] wd[$];

  always #25 clk_i = ~clk_i;
  // open-drain data wire with pull-up
  assign sda_w = ctl_sda & ~(sda_oe_o & ~sda_o);

  ee2w_target #(.WR_CYCLES(WR_CYC), .DEV_TYPE(DEV_CODE)) DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .select_strap_bit2_i(strap[2]),
    .select_strap_bit1_i(strap[1]), .select_strap_bit0_i(strap[0]),
    .wp_i(wp_i), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
    .mem_data_o(mem_data_o), .standby_o(standby_o),
    .write_busy_o(write_busy_o));
  ee2w_ctrl_model CTL (.sda_i(sda_w), .scl_o(scl), .sda_o(ctl_sda));

  // array strobes logged mid-cycle, clear of the launching edge
  always @(negedge clk_i) begin
    if (mem_we_o === 1'b1) begin
      wa.push_back(mem_addr_o);
      wd.push_back(mem_data_o);
    end
  end

  // hang guard, well above the few thousand cycles expected
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // frames
  // ----------------------------------------------------------------
  task automatic wframe(input logic [7:0] s, input logic sa, ra,
                        input logic [7:0] ah, al, d0, input int n);
    logic ack;
    CTL.frame_start();
    CTL.put_byte(s, ack);
    check("select ack", ack, sa);
    CTL.put_byte(ah, ack);
    check("addr hi ack", ack, ra);
    CTL.put_byte(al, ack);
    check("addr lo ack", ack, ra);
    for (int i = 0; i < n; i++) begin
      CTL.put_byte(d0 + 8'(i), ack);
      check("data ack", ack, ra);
    end
    CTL.frame_stop();
    @(negedge clk_i);
  endtask

  task automatic poll(output logic ack);
    CTL.frame_start();
    CTL.put_byte(SEL_W, ack);
    CTL.frame_stop();
    @(negedge clk_i);
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    while (standby_o !== 1'b1 && k < 2000) begin
      @(negedge clk_i);
      k++;
    end
    check("back to standby", k < 2000, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_byte_poll();
    logic ack;
    wa.delete();
    wd.delete();
    // top three address bits are don't-care
    wframe(SEL_W, 1'b1, 1'b1, 8'hE3, 8'h45, 8'hA7, 1);
    check("busy after stop", write_busy_o, 1'b1);
    check("no standby when busy", standby_o, 1'b0);
    poll(ack);
    check("poll while busy", ack, 1'b0);
    wait_idle();
    check("bytes written", wa.size(), 1);
    check("byte address", wa[0], 13'h0345);
    check("byte data", wd[0], 8'hA7);
    poll(ack);
    check("poll when done", ack, 1'b1);
    check("empty frame idle", write_busy_o, 1'b0);
    $display("byte write and polling done");
  endtask

  task automatic t_page_wrap();
    logic [7:0] exp [32];
    wa.delete();
    wd.delete();
    for (int i = 0; i < 34; i++) begin
      exp[(30 + i) % 32] = 8'h40 + 8'(i);
    end
    wframe(SEL_W, 1'b1, 1'b1, 8'h01, 8'h5E, 8'h40, 34);
    wait_idle();
    check("page byte count", wa.size(), 32);
    foreach (wd[i]) begin
      check("page address", wa[i], {8'h0A, 5'(i)});
      check("page data", wd[i], exp[i]);
    end
    $display("page wrap done");
  endtask

  task automatic t_refuse();
    logic [7:0] sel [3];
    sel = '{{~DEV_CODE, STRAP, 1'b0}, {DEV_CODE, STRAP ^ 3'h1, 1'b0},
            {DEV_CODE, STRAP, 1'b1}};
    wa.delete();
    for (int i = 0; i < 3; i++) begin
      wframe(sel[i], 1'(i == 2), 1'b0, 8'h00, 8'h20, 8'h11, 1);
      check("no cycle", write_busy_o, 1'b0);
    end
    check("nothing written", wa.size(), 0);
    $display("refusal done");
  endtask

  task automatic t_protect();
    logic [7:0] ah [3];
    ah = '{8'h18, 8'h08, 8'h18};
    for (int i = 0; i < 3; i++) begin
      wp_i = 1'(i < 2);
      wa.delete();
      wframe(SEL_W, 1'b1, 1'b1, ah[i], 8'h07, 8'h5A, 1);
      wait_idle();
      check("protect count", wa.size(), 32'(i > 0));
    end
    wp_i = 1'b0;
    $display("write protect done");
  endtask

  initial begin
    @(negedge clk_i);
    strap = STRAP;
    repeat (5) @(negedge clk_i);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    check("reset standby", standby_o, 1'b1);
    check("reset busy", write_busy_o, 1'b0);
    check("reset drive", sda_oe_o, 1'b0);
    repeat (4) @(negedge clk_i);
    CTL.recover(bus_free);
    check("bus free", bus_free, 1'b1);
    @(negedge clk_i);
    t_byte_poll();
    t_page_wrap();
    t_refuse();
    t_protect();
    summarize();
  end
endmodule // tb_serial_eeprom_two_wire_target
